// >>> rtl/crc8_serial.sv
module crc8_serial
  import rom_id_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic shiftEn,
  input wire logic dataBit,
  // result
  output logic [7:0] crc,
  output logic zero
);

  logic fb;

  assign fb = dataBit ^ crc[0];

  always_ff @(posedge mclk) begin
    if (rst || clear) begin
      crc <= CRC_INIT;
    end else if (shiftEn) begin
      crc <= (crc >> 1) ^ (fb ? CRC_POLY : 8'h00);
    end
  end

  assign zero = (crc == 8'h00);

endmodule // crc8_serial

// >>> rtl/rom_id_layer.sv
// Overview of operation
// - 64-bit identifier, family code sent first
// - 36-bit serial number follows family code
// - 12-bit range code follows serial
// - last byte is CRC of 56 bits
// - CRC polynomial x^8+x^5+x^4+1 shift register
// - CRC register cleared before first bit
// - bits enter CRC lsb first, one per step
// - CRC over all 64 bits yields zero
// - high-speed command switches to fast mode
// - memory commands only after ROM command success
// - all bytes travel least significant bit first
// - ROM layer runs without battery power
module rom_id_layer
  import rom_id_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bit slots from the line layer
  input wire logic resetPulse,
  input rom_id_pkg::slot_t slot,
  output logic txBit,
  output logic slotAck,
  // speed and status
  output logic fastMode,
  output logic memAccess,
  output logic crcOk,
  // memory command byte to the memory layer
  output rom_id_pkg::byte_t memCmd,
  // power source, informative
  input wire logic batteryOk
);

  typedef enum {S_IDLE, S_CMD, S_SEND, S_MATCH, S_SRCH_A, S_SRCH_B, S_SRCH_W,
                S_MEM, S_DONE} state_t;

  state_t state_reg;
  logic [ID_BITS-1:0] romId;
  logic [7:0] cmd_reg;
  logic [2:0] bitCnt_reg;
  logic [5:0] idx_reg;
  logic [7:0] crcCalc;
  logic crcClear, crcShift, crcZero;
  logic [ID_BITS-1:0] idShadow_reg;
  logic [6:0] chkCnt_reg;
  logic fastCmd, lastBit, slotTaken;
  logic [7:0] cmd_next;
  logic [7:0] crcByte_reg;

  ////////////////////////////////////////////////////////////////////////////
  // identifier assembly, family byte at bit 0 goes first
  assign romId[FAMILY_LSB +: FAMILY_BITS] = FAMILY_DEFAULT;
  assign romId[SERIAL_LSB +: SERIAL_BITS] = SERIAL_DEFAULT;
  assign romId[RANGE_LSB +: RANGE_BITS] = RANGE_DEFAULT;
  assign romId[CRC_LSB +: CRC_BITS] = crcByte_reg;

  ////////////////////////////////////////////////////////////////////////////
  // crc over the first 56 bits, computed once after reset, then kept
  crc8_serial crcUnit (
    .mclk(mclk),
    .rst(rst),
    .clear(crcClear),
    .shiftEn(crcShift),
    .dataBit(idShadow_reg[0]),
    .crc(crcCalc),
    .zero(crcZero)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      chkCnt_reg <= 7'h00;
      idShadow_reg <= '0;
      crcByte_reg <= CRC_INIT;
    end else if (chkCnt_reg == 7'h00) begin
      chkCnt_reg <= 7'h01;
      idShadow_reg <= {8'h00, romId[CRC_LSB-1:0]};
    end else if (chkCnt_reg == 7'h39) begin
      // keep the generated byte, then run it through the engine as a check
      chkCnt_reg <= 7'h3A;
      crcByte_reg <= crcCalc;
      idShadow_reg <= {56'h0, crcCalc};
    end else if (chkCnt_reg <= 7'h41) begin
      chkCnt_reg <= chkCnt_reg + 7'h01;
      idShadow_reg <= idShadow_reg >> 1;
    end
  end

  // engine idles once the check is over
  assign crcClear = (chkCnt_reg == 7'h00);
  assign crcShift = ((chkCnt_reg >= 7'h01) && (chkCnt_reg <= 7'h38))
                    || ((chkCnt_reg >= 7'h3A) && (chkCnt_reg <= 7'h41));

  // self check: all 64 identifier bits leave the engine at zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      crcOk <= 1'b0;
    end else begin
      crcOk <= (chkCnt_reg == 7'h42) && crcZero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer; runs regardless of batteryOk
  assign cmd_next = {slot.wbit, cmd_reg[7:1]};
  assign fastCmd = (cmd_next == CMD_FAST_SKIP) || (cmd_next == CMD_FAST_MATCH);
  assign lastBit = (bitCnt_reg == 3'h7);
  // a slot loses to a line reset in the same cycle
  assign slotTaken = slot.want && !resetPulse;

  ////////////////////////////////////////////////////////////////////////////
  // speed switch when a high-speed command byte completes
  always_ff @(posedge mclk) begin
    if (rst) begin
      fastMode <= 1'b0;
    end else if (slotTaken && (state_reg == S_CMD) && lastBit && fastCmd) begin
      fastMode <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first memory command byte, gathered lsb first
  always_ff @(posedge mclk) begin
    if (rst) begin
      memCmd <= '0;
    end else begin
      memCmd.valid <= 1'b0;
      if (slotTaken && (state_reg == S_MEM)) begin
        memCmd.data <= {slot.wbit, memCmd.data[7:1]};
        memCmd.valid <= lastBit;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cmd_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      idx_reg <= 6'h00;
      memAccess <= 1'b0;
    end else begin
      if (resetPulse) begin
        state_reg <= S_CMD;
        bitCnt_reg <= 3'h0;
        idx_reg <= 6'h00;
        memAccess <= 1'b0;
      end else if (slot.want) begin
        case (state_reg)
          S_CMD: begin
            cmd_reg <= cmd_next;
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (lastBit) begin
              idx_reg <= 6'h00;
              case (cmd_next)
                CMD_READ: state_reg <= S_SEND;
                CMD_MATCH, CMD_FAST_MATCH: state_reg <= S_MATCH;
                CMD_SEARCH: state_reg <= S_SRCH_A;
                CMD_COND_SEARCH: state_reg <= S_SRCH_A;
                CMD_SKIP, CMD_FAST_SKIP: begin
                  state_reg <= S_MEM;
                  memAccess <= 1'b1;
                end
                default: state_reg <= S_DONE;
              endcase
            end
          end
          S_SEND: begin
            idx_reg <= idx_reg + 6'h01;
            if (idx_reg == 6'h3F) begin
              state_reg <= S_MEM;
              memAccess <= 1'b1;
            end
          end
          S_MATCH: begin
            idx_reg <= idx_reg + 6'h01;
            if (slot.wbit != romId[idx_reg]) begin
              state_reg <= S_DONE;
            end else if (idx_reg == 6'h3F) begin
              state_reg <= S_MEM;
              memAccess <= 1'b1;
            end
          end
          S_SRCH_A: state_reg <= S_SRCH_B;
          S_SRCH_B: state_reg <= S_SRCH_W;
          S_SRCH_W: begin
            idx_reg <= idx_reg + 6'h01;
            if (slot.wbit != romId[idx_reg]) begin
              state_reg <= S_DONE;
            end else if (idx_reg == 6'h3F) begin
              state_reg <= S_MEM;
              memAccess <= 1'b1;
            end else begin
              state_reg <= S_SRCH_A;
            end
          end
          S_MEM: begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (lastBit) begin
              state_reg <= S_DONE;
            end
          end
          S_IDLE, S_DONE: state_reg <= state_reg;
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit answered to the master on read slots
  always_comb begin
    case (state_reg)
      S_SEND, S_SRCH_A: txBit = romId[idx_reg];
      S_SRCH_B: txBit = ~romId[idx_reg];
      default: txBit = 1'b1;
    endcase
  end

  assign slotAck = slot.want;

endmodule // rom_id_layer

// >>> rtl/rom_id_pkg.sv
package rom_id_pkg;

  // identifier layout
  localparam int ID_BITS = 64;
  localparam int FAMILY_LSB = 0;
  localparam int FAMILY_BITS = 8;
  localparam int SERIAL_LSB = 8;
  localparam int SERIAL_BITS = 36;
  localparam int RANGE_LSB = 44;
  localparam int RANGE_BITS = 12;
  localparam int CRC_LSB = 56;
  localparam int CRC_BITS = 8;
  localparam int BYTE_BITS = 8;

  // generator x^8 + x^5 + x^4 + 1, reflected form for right shift
  localparam logic [7:0] CRC_POLY = 8'h8C;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // identity values, arbitrary
  localparam logic [7:0] FAMILY_DEFAULT = 8'h5A;
  localparam logic [35:0] SERIAL_DEFAULT = 36'h123456789;
  localparam logic [11:0] RANGE_DEFAULT = 12'hA5C;

  // rom-level command codes, arbitrary
  localparam logic [7:0] CMD_READ = 8'h33;
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam logic [7:0] CMD_COND_SEARCH = 8'hEC;
  localparam logic [7:0] CMD_SKIP = 8'hCC;
  localparam logic [7:0] CMD_FAST_SKIP = 8'h3C;
  localparam logic [7:0] CMD_FAST_MATCH = 8'h69;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_t;

  typedef struct packed {
    logic want;   // master asks for a bit
    logic wbit;   // bit the master writes
    logic write;  // master writes (else reads)
  } slot_t;

endpackage

// >>> testbench/bus_master_model.sv
module bus_master_model
  import rom_id_pkg::*;
(
  // clock
  input wire logic mclk,
  // slot side
  input wire logic txBit,
  input wire logic slotAck,
  output logic resetPulse,
  output rom_id_pkg::slot_t slot
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;
  int acks = 0;
  initial begin
    resetPulse = 1'b0;
    slot = '0;
  end
  task automatic line_reset();
    @(negedge mclk) resetPulse = 1'b1;
    @(negedge mclk) resetPulse = 1'b0;
  endtask
  // written bit is turned round after the slot so a stale level is never taken as data
  task automatic do_slot(input logic w, input logic b, output logic r);
    @(negedge mclk) slot = '{want: 1'b1, wbit: b, write: w};
    #1 r = txBit;
    if (slotAck === 1'b1) acks++;
    @(negedge mclk) slot = '{want: 1'b0, wbit: ~b, write: w};
    repeat (gap) @(negedge mclk);
  endtask
  task automatic wr_byte(input logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++) do_slot(1'b1, v[i], r);
  endtask
  task automatic rd_bits(input int n, output logic [63:0] v);
    for (int i = 0; i < n; i++) do_slot(1'b0, 1'b1, v[i]);
  endtask
endmodule  // bus_master_model

// >>> testbench/rom_id_layer_asserts.sv
module rom_id_layer_asserts
  import rom_id_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic resetPulse,
  input rom_id_pkg::slot_t slot,
  input wire logic fastMode,
  input wire logic memAccess,
  input wire logic crcOk,
  input rom_id_pkg::byte_t memCmd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff rst;
  chk_crc_ready: assert property ($fell(rst) |-> ##[1:80] crcOk)
    else $error("self check late");
  chk_crc_stays: assert property (crcOk |=> crcOk)
    else $error("self check dropped");
  chk_fast_sticky: assert property (fastMode |=> fastMode)
    else $error("fast mode dropped");
  chk_fast_cause: assert property ($rose(fastMode) |-> $past(slot.want) || $past(slot.want, 2))
    else $error("fast mode without slot");
  chk_mem_cause: assert property ($rose(memAccess) |-> $past(slot.want) || $past(slot.want, 2))
    else $error("access without slot");
  chk_mem_cleared: assert property (resetPulse |=> !memAccess)
    else $error("access kept over line reset");
  chk_cmd_access: assert property (memCmd.valid |-> memAccess)
    else $error("command without access");
  chk_cmd_pulse: assert property (memCmd.valid |-> ($past(slot.want) || $past(slot.want, 2)) ##1 !memCmd.valid)
    else $error("command pulse wrong");
  cover property (memCmd.valid);
  cover property ($rose(fastMode));
  cover property (memAccess && crcOk);
endmodule  // rom_id_layer_asserts

bind rom_id_layer rom_id_layer_asserts chk (.mclk(mclk), .rst(rst), .resetPulse(resetPulse),
  .slot(slot), .fastMode(fastMode), .memAccess(memAccess), .crcOk(crcOk), .memCmd(memCmd));

// >>> testbench/rom_id_layer_tb.sv
`define CHK(n, e, a) begin totalChecks++; if ((a) !== (e)) begin nFail++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module rom_id_layer_tb;
  import rom_id_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, batteryOk = 1'b0;
  logic txBit, slotAck, fastMode, memAccess, crcOk, resetPulse;
  slot_t slot;
  byte_t memCmd;
  int nFail = 0, totalChecks = 0;
  logic [63:0] idExp, idGot;
  always #50 mclk = ~mclk;
  rom_id_layer uut (.mclk(mclk), .rst(rst), .resetPulse(resetPulse), .slot(slot),
    .txBit(txBit), .slotAck(slotAck), .fastMode(fastMode), .memAccess(memAccess),
    .crcOk(crcOk), .memCmd(memCmd), .batteryOk(batteryOk));
  bus_master_model bm (.mclk(mclk), .txBit(txBit), .slotAck(slotAck),
    .resetPulse(resetPulse), .slot(slot));
  function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) c = (c >> 1) ^ ((d[i] ^ c[0]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic do_reset();
    @(negedge mclk) rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (100) if (crcOk !== 1'b1) @(negedge mclk);
    `CHK("crcOk", 1'b1, crcOk)
    `CHK("fastMode", 1'b0, fastMode)
    `CHK("idle txBit", 1'b1, txBit)
    `CHK("memAccess", 1'b0, memAccess)
  endtask
  task automatic t_read();
    bm.line_reset();
    bm.wr_byte(CMD_READ);
    bm.rd_bits(64, idGot);
    `CHK("family", FAMILY_DEFAULT, idGot[7:0])
    `CHK("serial", SERIAL_DEFAULT, idGot[43:8])
    `CHK("range", RANGE_DEFAULT, idGot[55:44])
    `CHK("crc", idExp[63:56], idGot[63:56])
    `CHK("residue", 8'h00, crc_of(idGot, 64))
    `CHK("memAccess", 1'b1, memAccess)
  endtask
  task automatic t_match(input logic bad);
    bm.line_reset();
    `CHK("memAccess", 1'b0, memAccess)
    bm.wr_byte(CMD_MATCH);
    for (int i = 0; i < 8; i++) bm.wr_byte(idExp[8*i +: 8] ^ {7'h00, bad && i == 0});
    `CHK("match", ~bad, memAccess)
  endtask
  task automatic t_mem();
    logic seen;
    bm.line_reset();
    bm.acks = 0;
    bm.gap = 2;
    bm.wr_byte(CMD_SKIP);
    bm.gap = 0;
    `CHK("memAccess", 1'b1, memAccess)
    bm.wr_byte(8'hA6);
    seen = 1'b0;
    repeat (3) begin
      if (memCmd.valid === 1'b1 && !seen) begin
        seen = 1'b1;
        `CHK("memCmd", 8'hA6, memCmd.data)
      end
      @(negedge mclk);
    end
    `CHK("memCmd.valid", 1'b1, seen)
    `CHK("slotAck", 16, bm.acks)
  endtask
  task automatic t_cmds();
    logic [7:0] cmds[5] = '{CMD_READ, CMD_MATCH, CMD_SEARCH, CMD_COND_SEARCH, CMD_SKIP};
    foreach (cmds[i]) begin
      bm.line_reset();
      bm.wr_byte(cmds[i]);
      `CHK("slow", 1'b0, fastMode)
    end
    bm.line_reset();
    bm.wr_byte(CMD_FAST_MATCH);
    `CHK("fastMode", 1'b1, fastMode)
    do_reset();
    bm.line_reset();
    bm.wr_byte(CMD_FAST_SKIP);
    `CHK("fastMode", 1'b1, fastMode)
    `CHK("memAccess", 1'b1, memAccess)
  endtask
  // per identifier bit: read true bit, read complement, write the bit back
  task automatic t_search(input logic [7:0] cmd);
    logic [63:0] tru, cmp;
    logic r;
    bm.line_reset();
    batteryOk = 1'b1;
    bm.wr_byte(cmd);
    for (int i = 0; i < 64; i++) begin
      bm.do_slot(1'b0, 1'b1, tru[i]);
      bm.do_slot(1'b0, 1'b1, cmp[i]);
      bm.do_slot(1'b1, idExp[i], r);
    end
    `CHK("search bits", idExp, tru)
    `CHK("search complement", ~idExp, cmp)
    `CHK("memAccess", 1'b1, memAccess)
    batteryOk = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    idExp[55:0] = {RANGE_DEFAULT, SERIAL_DEFAULT, FAMILY_DEFAULT};
    idExp[63:56] = crc_of(idExp, 56);
    do_reset();
    t_read();
    t_match(1'b1);
    t_match(1'b0);
    t_mem();
    t_search(CMD_SEARCH);
    t_search(CMD_COND_SEARCH);
    t_cmds();
    results();
  end
  // watchdog
  initial begin
    #2000000;
    nFail++;
    results();
  end
endmodule  // rom_id_layer_tb
